// File: src/kspc_pkg.sv
`default_nettype none

package kspc_pkg;

    // Width of one configuration word.
    localparam int unsigned WORD_W = 8;

    // Width of the received-bit counter.
    localparam int unsigned CNT_W = 4;

    // Bit count that makes a frame acceptable.
    localparam logic [3:0] BITS_PER_FRAME = 4'h8;

    // Counter value that marks a frame as too long; the counter stops here.
    localparam logic [3:0] COUNT_OVER = 4'h9;

    // Counter value after the first falling edge of a frame.
    localparam logic [3:0] COUNT_FIRST = 4'h1;

    // Reset values.
    localparam logic [3:0] COUNT_RESET = 4'h0;
    localparam logic [7:0] WORD_RESET  = 8'h00;

    // The prescaler word is told apart by its two top bits.
    localparam logic [1:0] PRESCALE_TAG     = 2'h1;
    localparam int unsigned PRESCALE_TAG_HI = 7;
    localparam int unsigned PRESCALE_TAG_LO = 6;

    // Bit of the prescaler word that forces the data output off.
    localparam int unsigned HIZ_BIT = 0;

    // Snapshot of a frame as seen after chip select rises.
    typedef struct packed {
        logic [3:0] count;
        logic [7:0] word;
    } kspc_frame_t;

endpackage

`default_nettype wire

// File: src/kspc_port.sv
// What this block does
// - A transfer is a frame that carries exactly one 8-bit setting word.
// - With chip select high, clock and data are ignored and the output is off.
// - Each falling clock edge in a frame shifts one input bit in.
// - The word travels most significant bit first and is assembled so.
// - A frame with other than eight bits is dropped and the old word stays.
// - The word is latched only after eight edges when chip select rises.
// - While the integrate/hold input is high every frame is ignored.
// - In hold mode any number of frames is accepted.
// - A bit of the prescaler word forces the output off over chip select.
`timescale 1ns/1ps
`default_nettype none

module kspc_port (
    input  wire logic       sys_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       sclk_in,
    input  wire logic       cs_n_in,
    input  wire logic       sdi_in,
    input  wire logic       int_hold_in,
    output logic            sdo_out,
    output logic            sdo_oe_n_out,
    output logic [7:0]      cfg_word_out,
    output logic            cfg_valid_out,
    output logic            hiz_forced_out
);

    ////////////////////////////////////////////////////////////////////////
    // Link side, clocked by the falling edge of the serial clock.

    logic                   fresh;
    logic [3:0]             count;
    logic [3:0]             next_count;
    logic [7:0]             shift;
    logic [7:0]             next_shift;

    // Marks the first edge of a frame; held set while chip select is high.
    // counter restart
    always_ff @(negedge sclk_in or posedge cs_n_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            fresh <= 1'b1;
        end else if (cs_n_in) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // Next bit count and shift value; nothing moves while deselected.
    always_comb begin
        next_count = count;
        next_shift = shift;
        if (!cs_n_in) begin
            next_shift = {shift[6:0], sdi_in};
            if (fresh) begin
                next_count = kspc_pkg::COUNT_FIRST;
            end else if (count >= kspc_pkg::COUNT_OVER) begin
                next_count = count;
            end else begin
                next_count = 4'(count + 4'h1);
            end
        end
    end

    // Registers of the link side.
    always_ff @(negedge sclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count <= kspc_pkg::COUNT_RESET;
            shift <= kspc_pkg::WORD_RESET;
        end else begin
            count <= next_count;
            shift <= next_shift;
        end
    end

    // The data output shows the bit shifted out of the top of the register.
    assign sdo_out = shift[7];

    ////////////////////////////////////////////////////////////////////////
    // System side: synchronisers for chip select and integrate/hold.

    logic                   cs_meta;
    logic                   cs_sync;
    logic                   cs_prev;
    logic                   ih_meta;
    logic                   ih_sync;

    // Two flip-flops per pin, plus a third for chip select edges; logic reads the second stage and, for chip select, the third.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cs_meta <= 1'b1;
            cs_sync <= 1'b1;
            cs_prev <= 1'b1;
            ih_meta <= 1'b0;
            ih_sync <= 1'b0;
        end else begin
            cs_meta <= cs_n_in;
            cs_sync <= cs_meta;
            cs_prev <= cs_sync;
            ih_meta <= int_hold_in;
            ih_sync <= ih_meta;
        end
    end

    logic                   cs_rise;
    logic                   cs_fall;
    kspc_pkg::kspc_frame_t  frame;

    // The link side is idle while chip select is high, so its count and
    // word are steady when the system side samples them here.
    assign cs_rise     = cs_sync & ~cs_prev;
    assign cs_fall     = ~cs_sync & cs_prev;
    assign frame.count = count;
    assign frame.word  = shift;

    ////////////////////////////////////////////////////////////////////////
    // System side: frame acceptance, latch and output enable.

    logic                   int_seen;
    logic                   next_int_seen;
    logic [7:0]             next_cfg_word;
    logic                   next_cfg_valid;
    logic                   next_hiz;
    logic                   next_oe_n;
    logic                   accept;

    // Decide on each frame end and compute the latch and enable.
    always_comb begin
        next_int_seen  = int_seen;
        next_cfg_word  = cfg_word_out;
        next_hiz       = hiz_forced_out;
        if (cs_fall) begin
            next_int_seen = ih_sync;
        end else if (!cs_sync && ih_sync) begin
            next_int_seen = 1'b1;
        end
        accept = cs_rise && !int_seen
                 && (frame.count == kspc_pkg::BITS_PER_FRAME);
        next_cfg_valid = accept;
        if (accept) begin
            next_cfg_word = frame.word;
            if (frame.word[kspc_pkg::PRESCALE_TAG_HI:kspc_pkg::PRESCALE_TAG_LO]
                == kspc_pkg::PRESCALE_TAG) begin
                next_hiz = frame.word[kspc_pkg::HIZ_BIT];
            end
        end
        next_oe_n = cs_sync | next_hiz;
    end

    // Registers of the system side.
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            int_seen       <= 1'b0;
            cfg_word_out   <= kspc_pkg::WORD_RESET;
            cfg_valid_out  <= 1'b0;
            hiz_forced_out <= 1'b0;
            sdo_oe_n_out   <= 1'b1;
        end else begin
            int_seen       <= next_int_seen;
            cfg_word_out   <= next_cfg_word;
            cfg_valid_out  <= next_cfg_valid;
            hiz_forced_out <= next_hiz;
            sdo_oe_n_out   <= next_oe_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the system side.

    sequence seq_frame_end;
        cs_sync && !cs_prev;
    endsequence

    sequence seq_good_end;
        seq_frame_end ##0 (count == kspc_pkg::BITS_PER_FRAME) ##0 !int_seen;
    endsequence

    good_latch_a : assert property (
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        seq_good_end |=> cfg_valid_out && (cfg_word_out == $past(shift)))
        else $error("good frame not latched");

    bad_count_a : assert property (
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        seq_frame_end ##0 (count != kspc_pkg::BITS_PER_FRAME)
        |=> !cfg_valid_out && $stable(cfg_word_out))
        else $error("frame with wrong count latched");

    int_block_a : assert property (
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        seq_frame_end ##0 int_seen |=> !cfg_valid_out && $stable(cfg_word_out))
        else $error("frame latched in integration mode");

    word_hold_a : assert property (
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        !cfg_valid_out |-> $stable(cfg_word_out))
        else $error("word changed without latch");

    valid_pulse_a : assert property (
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        cfg_valid_out |=> !cfg_valid_out)
        else $error("latch pulse longer than a cycle");

    desel_off_a : assert property (
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        cs_sync [*2] |-> sdo_oe_n_out)
        else $error("output driven while deselected");

    forced_off_a : assert property (
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        hiz_forced_out |-> sdo_oe_n_out)
        else $error("output driven while forced off");

    sel_drive_a : assert property (
        @(posedge sys_clk_in) disable iff (!reset_n_in)
        !cs_sync && !next_hiz |=> !sdo_oe_n_out)
        else $error("output not driven while selected");

    ////////////////////////////////////////////////////////////////////////
    // Checks on the link side.

    msb_first_a : assert property (
        @(negedge sclk_in) disable iff (!reset_n_in || cs_n_in)
        !fresh |=> shift == {$past(shift[6:0]), $past(sdi_in)})
        else $error("input bit not shifted in at the bottom");

    count_restart_a : assert property (
        @(negedge sclk_in) disable iff (!reset_n_in || cs_n_in)
        $fell(fresh) |-> count == kspc_pkg::COUNT_FIRST)
        else $error("counter did not restart at frame start");

endmodule

`default_nettype wire

// File: dv/kspc_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host model: sends frames on the serial link, paced by the link clock.
module kspc_host (
    input  wire logic lclk_in,
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      sdi_out
);
    // Idle lines: select off, clock low, data at its pull-up level.
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out  = 1'b1;
    end
    // Sends the low n bits of w, one bit per falling clock edge.
    task automatic send(input logic [8:0] w, input int n);
        // Keeps the gap since the last frame above the minimum.
        repeat (12) @(posedge lclk_in);
        @(posedge lclk_in) #1 cs_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge lclk_in) #1 sdi_out = w[i];
            repeat (4) @(posedge lclk_in);
            #1 sclk_out = 1'b1;
            repeat (4) @(posedge lclk_in);
            #1 sclk_out = 1'b0;
        end
        repeat (6) @(posedge lclk_in);
        #1 cs_n_out = 1'b1;
        sdi_out = 1'b1;
    endtask
    // Wiggles clock and data with select high; the port must ignore it.
    task automatic noise();
        for (int i = 0; i < 8; i++) begin
            @(posedge lclk_in) #1 sclk_out = ~sclk_out;
            sdi_out = ~sdi_out;
        end
    endtask
endmodule
`default_nettype wire

// File: dv/test_knock_processor_spi_config_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_knock_processor_spi_config_port;
    logic        sys_clk_in  = 1'b0;
    logic        reset_n_in  = 1'b0;
    logic        lclk        = 1'b0;
    logic        int_hold_in = 1'b0;
    logic        sclk, cs_n, sdi, sdo, oe_n, valid, hiz;
    logic [7:0]  word;
    logic [7:0]  exp_word    = 8'h00;
    logic        exp_hiz     = 1'b0;
    logic [7:0]  exp_shift   = 8'h00;
    logic [7:0]  exp_q[$];
    logic [31:0] r;
    integer      seed        = 32'he96c;
    int          error_cnt   = 0;
    int          total_checks = 0;
    // System clock and an unrelated link timebase.
    always #5 sys_clk_in = ~sys_clk_in;
    always #7.5 lclk = ~lclk;
    kspc_host u_host (.lclk_in(lclk), .sclk_out(sclk), .cs_n_out(cs_n),
        .sdi_out(sdi));
    kspc_port i_kspc_port (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .sclk_in(sclk), .cs_n_in(cs_n), .sdi_in(sdi),
        .int_hold_in(int_hold_in), .sdo_out(sdo), .sdo_oe_n_out(oe_n),
        .cfg_word_out(word), .cfg_valid_out(valid), .hiz_forced_out(hiz));
    // Counts a comparison and reports a mismatch.
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Sends one frame, steps the model and compares the port with it.
    task automatic frame(input logic [8:0] w, input int n, input logic hold);
        logic acc;
        logic seen;
        acc = (n == 8) && !hold;
        seen = 1'b0;
        if (acc) exp_q.push_back(w[7:0]);
        @(posedge sys_clk_in) #1 int_hold_in = hold;
        fork
            u_host.send(w, n);
            begin
                repeat (40) @(posedge sys_clk_in);
                #1 check(oe_n === exp_hiz, "enable in frame");
            end
        join
        // The model shift register takes every bit sent, top bit first.
        for (int i = n - 1; i >= 0; i--) begin
            exp_shift = {exp_shift[6:0], w[i]};
        end
        for (int i = 0; i < 12; i++) begin
            @(posedge sys_clk_in) #1;
            if (valid === 1'b1) begin
                seen = 1'b1;
                check(word === exp_q[0], "word at pulse");
            end
        end
        if (acc) begin
            exp_word = exp_q.pop_front();
            if (exp_word[7:6] == 2'h1) exp_hiz = exp_word[0];
        end
        check(seen === acc, "accept pulse");
        check(word === exp_word, "latched word");
        check(hiz === exp_hiz, "forced off flag");
        check(oe_n === 1'b1, "output off when deselected");
        check(sdo === exp_shift[7], "echo bit");
        int_hold_in = 1'b0;
    endtask
    // Main sequence.
    initial begin
        repeat (3) @(posedge sys_clk_in);
        #1 reset_n_in = 1'b1;
        repeat (3) @(posedge sys_clk_in);
        #1 check(word === 8'h00 && oe_n === 1'b1, "reset state");
        check(hiz === 1'b0 && valid === 1'b0, "reset flags");
        for (int i = 0; i < 6; i++) begin
            r = $random(seed);
            frame(r[8:0], 8, 1'b0);
        end
        frame(9'h0a5, 7, 1'b0);
        frame(9'h15a, 9, 1'b0);
        frame(9'h03c, 8, 1'b0);
        frame(9'h0c3, 8, 1'b1);
        u_host.noise();
        repeat (3) @(posedge sys_clk_in);
        #1 check(sdo === exp_shift[7], "noise shifted");
        check(word === exp_word, "noise latched");
        frame(9'h081, 8, 1'b0);
        frame(9'h041, 8, 1'b0);
        frame(9'h0e7, 8, 1'b0);
        frame(9'h040, 8, 1'b0);
        print_verdict();
    end
    // Cuts a hang short: fourteen frames are sent; the limit allows sixteen frames of under 2 us each, three times over.
    localparam int WATCHDOG_NS = 16 * 2000 * 3;
    initial begin
        #(WATCHDOG_NS);
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule
`default_nettype wire
